// ### rtl/omc_pkg.sv
// Constants, register map and mode type of the operating mode controller
// How it works
// - Exactly four operating modes: high-speed run, low-speed run, sleep and idle.
// - High-speed run: CPU clock from high oscillator, executing, both oscillators running.
// - After any reset release the controller starts in high-speed run mode.
// - Clock select 0 gives high-speed run, 1 gives low-speed run from low oscillator.
// - Low-speed run steps the CPU at one quarter of the low oscillator rate.
// - Low-speed run keeps the high oscillator; only the stop bit halts it.
// - Sleep request 1 enters power down: no execution, all peripherals off.
// - Power down stops external high, internal PLL and external low oscillators.
// - Waking from power down clears the sleep request bit in hardware.
// - Power down leaves only on port 0, enabled port 1 or reset; resumes high-speed.
// - Idle request 1 enters idle mode; hardware clears it on wake.
// - Idle halts execution, keeps system oscillator, clocks the wake timer.
// - Idle leaves on port 0, enabled port 1, wake timer overflow or reset.
// - Idle wake returns to the run mode active when idle was entered.
// - In idle display, PWM and resistance-to-frequency follow enables; second timer stops.
// - Idle keeps only wake timer internal interrupt plus external ones; sleep disables all.
// - High oscillator stop in high-speed run leaves CPU clockless until pin wake.
// - Port 0 always wakes; each port 1 pin only with its enable bit, reset 0.
// - Wake from power down with external crystal waits 2560 oscillator cycles.
// - Idle wake has no warm-up wait.
package omc_pkg;

    // Register byte addresses
    localparam logic [7:0] OMC_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] OMC_ADDR_STATUS = 8'h04;
    localparam logic [7:0] OMC_ADDR_PERIPH = 8'h08;
    localparam logic [7:0] OMC_ADDR_P1WAKE = 8'hC0;

    // Control register fields
    localparam int OMC_CTRL_SLEEP  = 0;
    localparam int OMC_CTRL_IDLE   = 1;
    localparam int OMC_CTRL_HSTOP  = 2;
    localparam int OMC_CTRL_LOWSEL = 3;
    localparam int OMC_CTRL_PLL    = 4;

    // Peripheral enable register fields
    localparam int OMC_PER_TMR_A = 0;
    localparam int OMC_PER_TMR_B = 1;
    localparam int OMC_PER_TMR_C = 2;
    localparam int OMC_PER_DISP  = 3;
    localparam int OMC_PER_RFC   = 4;

    // Widths and reset values
    localparam int         OMC_P0_W        = 8;
    localparam int         OMC_P1_W        = 7;
    localparam logic [6:0] OMC_P1WAKE_RST  = 7'h00;
    localparam logic [4:0] OMC_PERIPH_RST  = 5'h00;

    // Warm-up of the external crystal, in high oscillator cycles
    localparam int          OMC_WARMUP_CYC = 2560;
    localparam logic [11:0] OMC_WARMUP_TOP = 12'(OMC_WARMUP_CYC - 1);

    // Last count of the low oscillator divider; the low-speed CPU step divides by this plus one
    localparam logic [1:0] OMC_SLOW_DIV_TOP = 2'h3;

    typedef enum logic [2:0] {
        OMC_RUN_HI,
        OMC_RUN_LO,
        OMC_GREEN,
        OMC_SLEEP,
        OMC_NOCLK,
        OMC_WARM
    } omc_mode_t;

endpackage : omc_pkg

// ### rtl/omc_wake_det.sv
// Wake pin synchroniser and two-edge detector
`timescale 1ns/100ps
`default_nettype none
module omc_wake_det
    import omc_pkg::*;
(
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    // Pins and enables
    input  wire logic [OMC_P0_W+OMC_P1_W-1:0] pins,
    input  wire logic [OMC_P0_W+OMC_P1_W-1:0] pin_en,
    // Wake pulse
    output logic                              wake
);
    localparam int N = OMC_P0_W + OMC_P1_W;

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
        logic         wake;
    } omc_wd_t;

    omc_wd_t s_q;
    omc_wd_t s_d;
    logic [N-1:0] edge_hit;

    // First stage feeds only the second stage
    generate
        for (genvar i = 0; i < N; i++) begin : g_pin
            assign edge_hit[i] = (s_q.s2[i] ^ s_q.s3[i]) & pin_en[i];
        end
    endgenerate

    always_comb begin
        s_d      = s_q;
        s_d.s1   = pins;
        s_d.s2   = s_q.s1;
        s_d.s3   = s_q.s2;
        s_d.wake = |edge_hit;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wake = s_q.wake;
endmodule : omc_wake_det
`default_nettype wire

// ### rtl/omc_slow_div.sv
// Quarter-rate step generator from low oscillator ticks
`timescale 1ns/100ps
`default_nettype none
module omc_slow_div
    import omc_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Control
    input  wire logic enable,
    input  wire logic losc_tick,
    // Step pulse
    output logic      step
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       step;
    } omc_sd_t;

    omc_sd_t s_q;
    omc_sd_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.step = 1'b0;
        if (!enable) begin
            s_d.cnt = 2'h0;
        end else if (losc_tick) begin
            s_d.cnt  = s_q.cnt + 2'h1;
            s_d.step = (s_q.cnt == OMC_SLOW_DIV_TOP);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign step = s_q.step;
endmodule : omc_slow_div
`default_nettype wire

// ### rtl/omc_mode_ctrl.sv
// Operating mode controller top with AHB-Lite register slave
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module omc_mode_ctrl
    import omc_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // Wake sources
    input  wire logic [OMC_P0_W-1:0] port0_pins,
    input  wire logic [OMC_P1_W-1:0] port1_pins,
    input  wire logic                wake_timer_ovf,
    input  wire logic                losc_tick,
    // Oscillator controls
    output logic                     ext_high_osc_en,
    output logic                     int_high_pll_osc_en,
    output logic                     ext_low_osc_en,
    output logic                     cpu_clk_low_sel,
    // CPU execution
    output logic                     cpu_run,
    output logic                     cpu_step,
    // Peripheral gates
    output logic                     wake_timer_clk_en,
    output logic                     wake_timer_active,
    output logic                     pwm_timer_active,
    output logic                     second_timer_active,
    output logic                     display_driver_active,
    output logic                     res_to_freq_active,
    // Interrupt gates
    output logic                     int_wake_timer_en,
    output logic                     int_other_en,
    output logic                     ext_int_en
);

    typedef struct packed {
        omc_mode_t   mode;
        omc_mode_t   green_ret;
        logic        sleep_request;
        logic        idle_request;
        logic        high_osc_stop;
        logic        low_speed_select;
        logic        use_pll;
        logic [6:0]  port1_wake_enable;
        logic [4:0]  periph_en;
        logic [11:0] warm_cnt;
        logic        ap_valid;
        logic        ap_write;
        logic [7:0]  ap_addr;
        logic [31:0] rdata;
        logic        ready;
        logic        ext_high_osc;
        logic        ipll;
        logic        ext_low_osc;
        logic        clk_low;
        logic        run;
        logic        step;
        logic        tclk;
        logic        tmr_a;
        logic        tmr_b;
        logic        tmr_c;
        logic        disp;
        logic        rfc;
        logic        irq_t;
        logic        irq_o;
        logic        irq_x;
    } omc_st_t;

    omc_st_t s_q;
    omc_st_t s_d;

    logic wake_pin;
    logic slow_step;
    logic wake_tmr;

    // Port 0 always armed, port 1 per enable
    omc_wake_det u_wake (
        .core_clk (core_clk),
        .rst      (rst),
        .pins     ({port1_pins, port0_pins}),
        .pin_en   ({s_q.port1_wake_enable, {OMC_P0_W{1'b1}}}),
        .wake     (wake_pin)
    );

    omc_slow_div u_slow (
        .core_clk  (core_clk),
        .rst       (rst),
        .enable    (s_q.mode == OMC_RUN_LO),
        .losc_tick (losc_tick),
        .step      (slow_step)
    );

    // Only the wake timer may end idle by overflow
    assign wake_tmr = wake_timer_ovf & s_q.periph_en[OMC_PER_TMR_A];

    function automatic logic [31:0] reg_read(input logic [7:0] a, input omc_st_t s);
        logic [31:0] r;
        r = 32'h0;
        if (a == OMC_ADDR_CTRL) begin
            r[OMC_CTRL_SLEEP]  = s.sleep_request;
            r[OMC_CTRL_IDLE]   = s.idle_request;
            r[OMC_CTRL_HSTOP]  = s.high_osc_stop;
            r[OMC_CTRL_LOWSEL] = s.low_speed_select;
            r[OMC_CTRL_PLL]    = s.use_pll;
        end else if (a == OMC_ADDR_STATUS) begin
            r[0] = (s.mode == OMC_RUN_HI);
            r[1] = (s.mode == OMC_RUN_LO);
            r[2] = (s.mode == OMC_GREEN);
            r[3] = (s.mode == OMC_SLEEP) || (s.mode == OMC_NOCLK);
            r[4] = (s.mode == OMC_WARM);
        end else if (a == OMC_ADDR_PERIPH) begin
            r[4:0] = s.periph_en;
        end else if (a == OMC_ADDR_P1WAKE) begin
            r[6:0] = s.port1_wake_enable;
        end
        return r;
    endfunction : reg_read

    function automatic logic is_live(input omc_mode_t m);
        return (m == OMC_RUN_HI) || (m == OMC_RUN_LO) || (m == OMC_GREEN);
    endfunction : is_live

    always_comb begin
        s_d       = s_q;
        s_d.ready = 1'b1;

        // Mode sequencing; hardware clears come before software writes
        case (s_q.mode)
            OMC_RUN_HI: begin
                if (s_q.sleep_request) begin
                    s_d.mode = OMC_SLEEP;
                end else if (s_q.idle_request) begin
                    s_d.mode      = OMC_GREEN;
                    s_d.green_ret = OMC_RUN_HI;
                end else if (s_q.low_speed_select) begin
                    s_d.mode = OMC_RUN_LO;
                end else if (s_q.high_osc_stop) begin
                    s_d.mode = OMC_NOCLK;
                end
            end
            OMC_RUN_LO: begin
                if (s_q.sleep_request) begin
                    s_d.mode = OMC_SLEEP;
                end else if (s_q.idle_request) begin
                    s_d.mode      = OMC_GREEN;
                    s_d.green_ret = OMC_RUN_LO;
                end else if (!s_q.low_speed_select) begin
                    s_d.mode = OMC_RUN_HI;
                end
            end
            OMC_SLEEP, OMC_NOCLK: begin
                if (wake_pin) begin
                    s_d.sleep_request    = 1'b0;
                    s_d.idle_request     = 1'b0;
                    s_d.low_speed_select = 1'b0;
                    s_d.high_osc_stop    = 1'b0;
                    if (s_q.use_pll) begin
                        s_d.mode = OMC_RUN_HI;
                    end else begin
                        s_d.mode     = OMC_WARM;
                        s_d.warm_cnt = OMC_WARMUP_TOP;
                    end
                end
            end
            OMC_WARM: begin
                if (s_q.warm_cnt == 12'h000) begin
                    s_d.mode = OMC_RUN_HI;
                end else begin
                    s_d.warm_cnt = s_q.warm_cnt - 12'h001;
                end
            end
            OMC_GREEN: begin
                if (wake_pin || wake_tmr) begin
                    s_d.idle_request = 1'b0;
                    s_d.mode         = s_q.green_ret;
                end
            end
            default: begin
                s_d.mode = OMC_RUN_HI;
            end
        endcase

        // Bus address phase, read data prepared for the data phase
        s_d.ap_valid = hsel & htrans[1] & hready;
        s_d.ap_write = hwrite;
        s_d.ap_addr  = haddr[7:0];
        s_d.rdata    = 32'h0;
        if (hsel && htrans[1] && hready && !hwrite) begin
            s_d.rdata = reg_read(haddr[7:0], s_q);
        end

        // Bus data phase write; a set here wins over a hardware clear
        if (s_q.ap_valid && s_q.ap_write) begin
            if (s_q.ap_addr == OMC_ADDR_CTRL) begin
                s_d.sleep_request    = hwdata[OMC_CTRL_SLEEP];
                s_d.idle_request     = hwdata[OMC_CTRL_IDLE];
                s_d.high_osc_stop    = hwdata[OMC_CTRL_HSTOP];
                s_d.low_speed_select = hwdata[OMC_CTRL_LOWSEL];
                s_d.use_pll          = hwdata[OMC_CTRL_PLL];
            end else if (s_q.ap_addr == OMC_ADDR_PERIPH) begin
                s_d.periph_en = hwdata[4:0];
            end else if (s_q.ap_addr == OMC_ADDR_P1WAKE) begin
                s_d.port1_wake_enable = hwdata[6:0];
            end
        end

        // Oscillators follow the next mode
        s_d.ext_high_osc = 1'b0;
        s_d.ipll  = 1'b0;
        if ((s_d.mode == OMC_RUN_HI) || (s_d.mode == OMC_WARM)) begin
            s_d.ext_high_osc = !s_d.use_pll;
            s_d.ipll  = s_d.use_pll;
        end else if ((s_d.mode == OMC_RUN_LO) || (s_d.mode == OMC_GREEN)) begin
            // Stop bit alone halts the high oscillator here
            s_d.ext_high_osc = !s_d.use_pll && !s_d.high_osc_stop;
            s_d.ipll  = s_d.use_pll && !s_d.high_osc_stop;
        end
        s_d.ext_low_osc   = is_live(s_d.mode) || (s_d.mode == OMC_WARM);
        s_d.clk_low = (s_d.mode == OMC_RUN_LO) ||
                      ((s_d.mode == OMC_GREEN) && (s_d.green_ret == OMC_RUN_LO));

        // Execution
        s_d.run  = (s_d.mode == OMC_RUN_HI) || (s_d.mode == OMC_RUN_LO);
        s_d.step = (s_d.mode == OMC_RUN_HI) ||
                   ((s_d.mode == OMC_RUN_LO) && slow_step);

        // Peripherals: off in sleep and during warm-up
        s_d.tclk  = (s_d.mode == OMC_GREEN) && s_d.periph_en[OMC_PER_TMR_A];
        s_d.tmr_a = is_live(s_d.mode) && s_d.periph_en[OMC_PER_TMR_A];
        s_d.tmr_b = is_live(s_d.mode) && s_d.periph_en[OMC_PER_TMR_B];
        s_d.tmr_c = s_d.run && s_d.periph_en[OMC_PER_TMR_C];
        s_d.disp  = is_live(s_d.mode) && s_d.periph_en[OMC_PER_DISP];
        s_d.rfc   = is_live(s_d.mode) && s_d.periph_en[OMC_PER_RFC];

        // Interrupt gating
        s_d.irq_t = is_live(s_d.mode);
        s_d.irq_o = s_d.run;
        s_d.irq_x = is_live(s_d.mode);
    end

    // Reset lands in high-speed run with its outputs already set
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q       <= '0;
            s_q.mode  <= OMC_RUN_HI;
            s_q.ready <= 1'b1;
            s_q.ext_high_osc <= 1'b1;
            s_q.ext_low_osc <= 1'b1;
            s_q.run   <= 1'b1;
            s_q.step  <= 1'b1;
            s_q.irq_t <= 1'b1;
            s_q.irq_o <= 1'b1;
            s_q.irq_x <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Bus outputs
    assign hrdata    = s_q.rdata;
    assign hreadyout = s_q.ready;
    assign hresp     = 1'b0;

    // Clock and execution outputs
    assign ext_high_osc_en     = s_q.ext_high_osc;
    assign int_high_pll_osc_en = s_q.ipll;
    assign ext_low_osc_en      = s_q.ext_low_osc;
    assign cpu_clk_low_sel     = s_q.clk_low;
    assign cpu_run             = s_q.run;
    assign cpu_step            = s_q.step;

    // Peripheral and interrupt outputs
    assign wake_timer_clk_en     = s_q.tclk;
    assign wake_timer_active     = s_q.tmr_a;
    assign pwm_timer_active      = s_q.tmr_b;
    assign second_timer_active   = s_q.tmr_c;
    assign display_driver_active = s_q.disp;
    assign res_to_freq_active    = s_q.rfc;
    assign int_wake_timer_en     = s_q.irq_t;
    assign int_other_en          = s_q.irq_o;
    assign ext_int_en            = s_q.irq_x;

    // Unused bus inputs: single word transfers only
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:8], htrans[0]};

endmodule : omc_mode_ctrl
`default_nettype wire

// ### bench/omc_mode_ctrl_monitor.sv
// Port-level checker of the operating mode controller
`timescale 1ns/100ps
`default_nettype none
module omc_mode_ctrl_monitor
    import omc_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // Wake pins
    input wire logic [7:0] port0_pins,
    input wire logic [6:0] port1_pins,
    // Mode outputs
    input wire logic       cpu_run,
    input wire logic       cpu_step,
    input wire logic       cpu_clk_low_sel,
    input wire logic       ext_high_osc_en,
    input wire logic       int_high_pll_osc_en,
    input wire logic       ext_low_osc_en,
    input wire logic       int_wake_timer_en,
    input wire logic       int_other_en,
    input wire logic       ext_int_en,
    input wire logic       second_timer_active,
    input wire logic       display_driver_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [3:0]  quiet_q;
    logic [14:0] pins_q;

    // Quiet edges since a pin moved
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            quiet_q <= 4'h0;
            pins_q  <= 15'h0;
        end else begin
            pins_q  <= {port1_pins, port0_pins};
            quiet_q <= (pins_q != {port1_pins, port0_pins}) ? 4'h0 : quiet_q + 4'(quiet_q != 4'hF);
        end
    end

    property p_reset_hi;
        $fell(rst) |-> cpu_run && cpu_step && !cpu_clk_low_sel && ext_high_osc_en && ext_low_osc_en;
    endproperty
    a_reset_hi: assert property (p_reset_hi) else $error("no high-speed run after reset");

    property p_run_hi;
        cpu_run && !cpu_clk_low_sel |-> cpu_step && ext_low_osc_en && (ext_high_osc_en || int_high_pll_osc_en);
    endproperty
    a_run_hi: assert property (p_run_hi) else $error("high-speed run lacks oscillators");

    property p_slow_step;
        cpu_run && cpu_clk_low_sel && cpu_step |=> !cpu_step || !cpu_clk_low_sel;
    endproperty
    a_slow_step: assert property (p_slow_step) else $error("long low-speed step");

    property p_down_oscs;
        !cpu_run && !ext_int_en && !ext_high_osc_en
            |-> !ext_low_osc_en && !int_high_pll_osc_en && !int_wake_timer_en && !display_driver_active;
    endproperty
    a_down_oscs: assert property (p_down_oscs) else $error("source on in power down");

    property p_idle_clock;
        !cpu_run && ext_int_en && int_wake_timer_en
            |-> !int_other_en && (cpu_clk_low_sel ? ext_low_osc_en : (ext_high_osc_en || int_high_pll_osc_en));
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("idle lost its system clock");

    property p_second_timer;
        second_timer_active |-> cpu_run;
    endproperty
    a_second_timer: assert property (p_second_timer) else $error("second timer outside run");

    property p_slow_resume;
        $rose(cpu_run) && cpu_clk_low_sel |-> $past(ext_int_en) && $past(ext_low_osc_en);
    endproperty
    a_slow_resume: assert property (p_slow_resume) else $error("low-speed resume not from idle");

    property p_no_pin_no_wake;
        !$past(cpu_run) && !$past(ext_low_osc_en) && !$past(ext_high_osc_en) && quiet_q > 4'h5
            |-> !ext_high_osc_en && !cpu_run;
    endproperty
    a_no_pin_no_wake: assert property (p_no_pin_no_wake) else $error("power down left without pin edge");
endmodule : omc_mode_ctrl_monitor

bind omc_mode_ctrl omc_mode_ctrl_monitor i_mon (.core_clk, .rst, .port0_pins, .port1_pins, .cpu_run, .cpu_step,
    .cpu_clk_low_sel, .ext_high_osc_en, .int_high_pll_osc_en, .ext_low_osc_en, .int_wake_timer_en, .int_other_en,
    .ext_int_en, .second_timer_active, .display_driver_active);
`default_nettype wire

// ### bench/omc_far_side.sv
// Far-side model: wake pins, wake timer overflow and low oscillator ticks
`timescale 1ns/100ps
`default_nettype none
module omc_far_side
    import omc_pkg::*;
#(
    parameter int LOSC_DIV = 4
)(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Bench commands
    input  wire logic [7:0] p0_flip,
    input  wire logic [6:0] p1_flip,
    input  wire logic       ovf_req,
    input  wire logic       ext_low_osc_en,
    // Toward the controller
    output logic [7:0]      port0_pins,
    output logic [6:0]      port1_pins,
    output logic            wake_timer_ovf,
    output logic            losc_tick
);
    int cnt;

    // Pins toggle, so both edge directions get exercised
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt            <= 0;
            port0_pins     <= '0;
            port1_pins     <= '0;
            wake_timer_ovf <= 1'b0;
            losc_tick      <= 1'b0;
        end else begin
            cnt            <= (cnt == LOSC_DIV - 1) ? 0 : cnt + 1;
            port0_pins     <= port0_pins ^ p0_flip;
            port1_pins     <= port1_pins ^ p1_flip;
            wake_timer_ovf <= ovf_req;
            losc_tick      <= ext_low_osc_en && (cnt == 0);
        end
    end
endmodule : omc_far_side
`default_nettype wire

// ### bench/test_omc_mode_ctrl.sv
// Self-checking bench of the operating mode controller
`timescale 1ns/100ps
`default_nettype none
module test_omc_mode_ctrl;
    import omc_pkg::*;

    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h0;
    logic [7:0]  p0_flip  = 8'h00;
    logic [6:0]  p1_flip  = 7'h00;
    logic        ovf_req  = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, wake_timer_ovf, losc_tick;
    logic [7:0]  port0_pins;
    logic [6:0]  port1_pins;
    logic        ext_high_osc_en, int_high_pll_osc_en, ext_low_osc_en, cpu_clk_low_sel, cpu_run, cpu_step;
    logic        wake_timer_clk_en, second_timer_active, int_other_en, ext_int_en;
    int          err_total  = 0;
    int          n_compared = 0;

    always #5 core_clk = ~core_clk;

    omc_far_side i_far (.core_clk, .rst, .p0_flip, .p1_flip, .ovf_req, .ext_low_osc_en,
        .port0_pins, .port1_pins, .wake_timer_ovf, .losc_tick);

    omc_mode_ctrl i_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .port0_pins, .port1_pins, .wake_timer_ovf,
        .losc_tick, .ext_high_osc_en, .int_high_pll_osc_en, .ext_low_osc_en, .cpu_clk_low_sel, .cpu_run,
        .cpu_step, .wake_timer_clk_en, .wake_timer_active(), .pwm_timer_active(), .second_timer_active,
        .display_driver_active(), .res_to_freq_active(), .int_wake_timer_en(), .int_other_en, .ext_int_en);

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bit_chk(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : bit_chk

    task automatic bail();
        err_total++;
        summarize();
    endtask : bail

    task automatic bus_phase(output logic [31:0] d);
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            d = hrdata;
            if (hreadyout === 1'b1) break;
        end
        if (n >= 50) bail();
    endtask : bus_phase

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        bus_phase(rd);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        bus_phase(rd);
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        chk(x, exp);
    endtask : rd

    task automatic flip(input logic [7:0] f0, input logic [6:0] f1, input logic ov);
        @(posedge core_clk);
        p0_flip <= f0;
        p1_flip <= f1;
        ovf_req <= ov;
        @(posedge core_clk);
        p0_flip <= 8'h00;
        p1_flip <= 7'h00;
        ovf_req <= 1'b0;
        @(posedge core_clk);
    endtask : flip

    task automatic wait_run(output int n);
        n = 0;
        while (n < 4000) begin
            @(negedge core_clk);
            if (cpu_run === 1'b1) break;
            n++;
        end
        if (n >= 4000) bail();
    endtask : wait_run

    task automatic look();
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask : look

    initial begin
        repeat (100000) @(posedge core_clk);
        bail();
    end

    initial begin
        int n, ns, nt;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rd(OMC_ADDR_STATUS, 32'h1);
        rd(OMC_ADDR_CTRL, 32'h0);
        rd(OMC_ADDR_P1WAKE, 32'h0);
        rd(8'h10, 32'h0);
        wr(OMC_ADDR_STATUS, 32'hFF);
        rd(OMC_ADDR_STATUS, 32'h1);
        $display("reset and registers done");

        wr(OMC_ADDR_CTRL, 32'h8);
        rd(OMC_ADDR_STATUS, 32'h2);
        @(negedge core_clk);
        bit_chk(ext_high_osc_en, 1'b1);
        ns = 0;
        nt = 0;
        repeat (256) begin
            @(negedge core_clk);
            ns += int'(cpu_step === 1'b1);
            nt += int'(losc_tick === 1'b1);
        end
        bit_chk(ns * 4 + 4 >= nt && ns * 4 <= nt + 4 && nt > 32, 1'b1);
        wr(OMC_ADDR_CTRL, 32'hC);
        look();
        bit_chk(ext_high_osc_en, 1'b0);
        $display("low-speed run done");

        wr(OMC_ADDR_CTRL, 32'hE);
        rd(OMC_ADDR_STATUS, 32'h4);
        look();
        bit_chk(cpu_run, 1'b0);
        bit_chk(ext_low_osc_en, 1'b1);
        bit_chk(int_other_en, 1'b0);
        bit_chk(ext_int_en, 1'b1);
        flip(8'h02, 7'h00, 1'b0);
        wait_run(n);
        bit_chk(n < 8, 1'b1);
        rd(OMC_ADDR_STATUS, 32'h2);
        rd(OMC_ADDR_CTRL, 32'hC);
        wr(OMC_ADDR_CTRL, 32'h0);
        rd(OMC_ADDR_STATUS, 32'h1);
        $display("idle from low speed done");

        wr(OMC_ADDR_PERIPH, 32'h5);
        wr(OMC_ADDR_CTRL, 32'h2);
        look();
        bit_chk(wake_timer_clk_en, 1'b1);
        bit_chk(second_timer_active, 1'b0);
        flip(8'h00, 7'h00, 1'b1);
        wait_run(n);
        bit_chk(n < 8, 1'b1);
        rd(OMC_ADDR_STATUS, 32'h1);
        rd(OMC_ADDR_CTRL, 32'h0);
        @(negedge core_clk);
        bit_chk(second_timer_active, 1'b1);
        $display("idle with timer wake done");

        wr(OMC_ADDR_PERIPH, 32'h0);
        wr(OMC_ADDR_CTRL, 32'h8);
        wr(OMC_ADDR_CTRL, 32'hB);
        rd(OMC_ADDR_STATUS, 32'h8);
        look();
        bit_chk(ext_low_osc_en | ext_high_osc_en | int_high_pll_osc_en, 1'b0);
        bit_chk(ext_int_en | cpu_run, 1'b0);
        flip(8'h00, 7'h40, 1'b1);
        repeat (12) @(posedge core_clk);
        rd(OMC_ADDR_STATUS, 32'h8);
        wr(OMC_ADDR_P1WAKE, 32'h40);
        rd(OMC_ADDR_P1WAKE, 32'h40);
        flip(8'h00, 7'h40, 1'b0);
        wait_run(n);
        bit_chk(n >= 2560 && n <= 2575, 1'b1);
        rd(OMC_ADDR_STATUS, 32'h1);
        rd(OMC_ADDR_CTRL, 32'h0);
        $display("power down done");

        wr(OMC_ADDR_CTRL, 32'h4);
        rd(OMC_ADDR_STATUS, 32'h8);
        flip(8'h80, 7'h00, 1'b0);
        wait_run(n);
        bit_chk(n >= 2560 && n <= 2575, 1'b1);
        rd(OMC_ADDR_STATUS, 32'h1);
        rd(OMC_ADDR_CTRL, 32'h0);
        $display("clockless stop done");
        summarize();
    end
endmodule : test_omc_mode_ctrl
`default_nettype wire
